// ==== hdl/scan_pkg.sv ====
package scan_pkg;
    localparam int CLK_NS = 20;
    localparam int SETUP_NS = 11300;
    localparam int LONG_NS = 5670;
    localparam int SHORT_NS = 3830;
    localparam int RELAY_NS = 1000;
    localparam int SETTLE_UNIT_NS = 1000;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int LONG_CYC = (LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int SHORT_CYC = (SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RELAY_CYC = (RELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 14;
    localparam int NUM_CELLS = 12;
    localparam logic [7:0] OFS_CHAN_CFG = 8'h08;
    localparam logic [7:0] OFS_CELL_EN = 8'h09;
    localparam logic [7:0] OFS_ACQ_CFG = 8'h0c;
    localparam logic [7:0] OFS_SCAN_CTRL = 8'h0e;
    localparam logic [7:0] OFS_CELL_DATA = 8'h20;
    localparam logic [7:0] OFS_AUX1 = 8'h2c;
    localparam logic [7:0] OFS_AUX2 = 8'h2d;
    localparam logic [7:0] OFS_DIAG = 8'h2e;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int SCAN_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int AUX1_EN_BIT = 0;
    localparam int AUX2_EN_BIT = 1;
    localparam int DIAG_EN_BIT = 2;
    localparam int MEM_AW = 6;
    localparam int MEM_DEPTH = 48;
    localparam logic [5:0] ADDR_DIAG = 6'h0c;
    localparam logic [5:0] ADDR_AUX1 = 6'h0e;
    localparam logic [5:0] P1_BASE = 6'h10;
    localparam logic [5:0] P2_BASE = 6'h20;
    localparam logic [3:0] CH_DIAG = 4'hd;
    localparam logic [3:0] CH_AUX1 = 4'he;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001, ST_SETUP = 9'h002, ST_CELL1 = 9'h004,
        ST_CELL2 = 9'h008, ST_WBACK = 9'h010, ST_DIAG1 = 9'h020,
        ST_DIAG2 = 9'h040, ST_AUXSET = 9'h080, ST_AUXCONV = 9'h100
    } state_t;

    // Highest enabled cell below index 'below'; bit 4 flags a hit
    function automatic logic [4:0] next_cell(input logic [11:0] mask, input logic [3:0] below);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (i < int'(below) && mask[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction
endpackage

// ==== hdl/scan_if.sv ====
`timescale 1ns/1ns
interface reg_wr_if;
    logic valid;
    logic bcast;
    logic [7:0] addr;
    logic [15:0] data;
    modport src(output valid, bcast, addr, data);
    modport dst(input valid, bcast, addr, data);
endinterface

interface mem_if;
    logic we;
    logic [5:0] waddr;
    logic [11:0] wdata;
    logic [5:0] raddr_a;
    logic [5:0] raddr_b;
    logic [11:0] rdata_a;
    logic [11:0] rdata_b;
    modport ctl(output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
    modport mem(input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

// ==== hdl/result_store.sv ====
`timescale 1ns/1ns
module result_store import scan_pkg::*; (
    input wire logic mclk,
    mem_if.mem m
);
    logic [11:0] store [MEM_DEPTH];

    always_ff @(posedge mclk) begin
        if (m.we) begin
            store[m.waddr] <= m.wdata;
        end
        m.rdata_a <= store[m.raddr_a];
        m.rdata_b <= store[m.raddr_b];
    end
endmodule

// ==== hdl/reg_write_sync.sv ====
`timescale 1ns/1ns
module reg_write_sync import scan_pkg::*; (
    input wire logic link_clk,
    input wire logic mclk,
    input wire logic rst,
    input wire logic link_wr,
    input wire logic link_bcast,
    input wire logic [7:0] link_addr,
    input wire logic [15:0] link_data,
    reg_wr_if.src wr
);
    logic lrst1_reg, lrst2_reg;
    logic tog_reg, tog_next;
    logic [24:0] hold_reg, hold_next;
    logic s1_reg, s2_reg, s3_reg, seen_reg, seen_next, fire;
    logic valid_reg;
    logic [24:0] out_reg, out_next;

    // Link side: capture the word and flip the toggle
    always_comb begin
        tog_next = tog_reg ^ link_wr;
        hold_next = link_wr ? {link_bcast, link_addr, link_data} : hold_reg;
    end

    always_ff @(posedge link_clk) begin
        lrst1_reg <= rst;
        lrst2_reg <= lrst1_reg;
        if (lrst2_reg) begin
            tog_reg <= 1'b0;
            hold_reg <= '0;
        end else begin
            tog_reg <= tog_next;
            hold_reg <= hold_next;
        end
    end

    // System side: toggle counts once second and third stage agree
    always_comb begin
        fire = (s2_reg == s3_reg) && (s3_reg != seen_reg);
        seen_next = fire ? s3_reg : seen_reg;
        out_next = fire ? hold_reg : out_reg;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            seen_reg <= 1'b0;
            valid_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            s1_reg <= tog_reg;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            seen_reg <= seen_next;
            valid_reg <= fire;
            out_reg <= out_next;
        end
    end

    assign wr.valid = valid_reg;
    assign wr.bcast = out_reg[24];
    assign wr.addr = out_reg[23:16];
    assign wr.data = out_reg[15:0];
endmodule

// ==== hdl/scan_seq_top.sv ====
`timescale 1ns/1ns
module scan_seq_top import scan_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_wr,
    input wire logic link_bcast,
    input wire logic [7:0] link_addr,
    input wire logic [15:0] link_data,
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic [11:0] adc_data,
    output logic [3:0] adc_chan,
    output logic adc_phase,
    output logic adc_start,
    output logic busy,
    output logic scan_fwd
);
    reg_wr_if w();
    mem_if m();

    reg_write_sync u_sync (
        .link_clk(link_clk),
        .mclk(mclk),
        .rst(rst),
        .link_wr(link_wr),
        .link_bcast(link_bcast),
        .link_addr(link_addr),
        .link_data(link_data),
        .wr(w)
    );

    result_store u_store (
        .mclk(mclk),
        .m(m)
    );

    function automatic logic [11:0] avg2(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[12:1];
    endfunction

    // Register file
    logic [15:0] chan_cfg_reg, chan_cfg_next, cell_en_reg, cell_en_next, acq_cfg_reg, acq_cfg_next;
    logic scan_bit_reg, scan_bit_next, wr_scan;

    always_comb begin
        chan_cfg_next = chan_cfg_reg;
        cell_en_next = cell_en_reg;
        acq_cfg_next = acq_cfg_reg;
        wr_scan = w.valid && w.addr == OFS_SCAN_CTRL && w.data[SCAN_BIT];
        if (w.valid) begin
            case (w.addr)
                OFS_CHAN_CFG: chan_cfg_next = w.data;
                OFS_CELL_EN: cell_en_next = w.data;
                OFS_ACQ_CFG: acq_cfg_next = w.data;
                default: ;
            endcase
        end
        // Bit lives one cycle; a new write wins over the self-clear
        scan_bit_next = wr_scan;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            chan_cfg_reg <= REG_RESET;
            cell_en_reg <= REG_RESET;
            acq_cfg_reg <= REG_RESET;
            scan_bit_reg <= 1'b0;
        end else begin
            chan_cfg_reg <= chan_cfg_next;
            cell_en_reg <= cell_en_next;
            acq_cfg_reg <= acq_cfg_next;
            scan_bit_reg <= scan_bit_next;
        end
    end

    // Broadcast relay up the ladder
    logic relay_act_reg, relay_act_next, fwd_reg, fwd_next;
    logic [5:0] relay_cnt_reg, relay_cnt_next;

    always_comb begin
        relay_act_next = relay_act_reg;
        relay_cnt_next = relay_cnt_reg;
        fwd_next = 1'b0;
        if (relay_act_reg) begin
            if (relay_cnt_reg == 6'h00) begin
                relay_act_next = 1'b0;
                fwd_next = 1'b1;
            end else begin
                relay_cnt_next = relay_cnt_reg - 6'h01;
            end
        end else if (wr_scan && w.bcast) begin
            relay_act_next = 1'b1;
            relay_cnt_next = 6'(RELAY_CYC - 1);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            relay_act_reg <= 1'b0;
            relay_cnt_reg <= 6'h00;
            fwd_reg <= 1'b0;
        end else begin
            relay_act_reg <= relay_act_next;
            relay_cnt_reg <= relay_cnt_next;
            fwd_reg <= fwd_next;
        end
    end

    // Scan sequencer
    state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next, settle_cyc;
    logic [3:0] idx_reg, idx_next, chan_reg, chan_next, l_chan;
    logic [11:0] cell_q_reg, cell_q_next, diag_p1_reg, diag_p1_next;
    logic [2:0] opt_q_reg, opt_q_next;
    logic [7:0] settle_q_reg, settle_q_next;
    logic phase_reg, phase_next, start_reg, start_next, busy_reg, busy_next;
    logic wb_ph_reg, wb_ph_next, launch, l_long, l_phase, after_cells, to_aux;
    logic [4:0] nc;

    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
        idx_next = idx_reg;
        cell_q_next = cell_q_reg;
        opt_q_next = opt_q_reg;
        settle_q_next = settle_q_reg;
        diag_p1_next = diag_p1_reg;
        chan_next = chan_reg;
        phase_next = phase_reg;
        start_next = 1'b0;
        busy_next = busy_reg;
        wb_ph_next = wb_ph_reg;
        launch = 1'b0;
        l_long = 1'b0;
        l_phase = 1'b0;
        l_chan = 4'h0;
        after_cells = 1'b0;
        to_aux = 1'b0;
        nc = 5'h00;
        settle_cyc = CNT_W'(32'(settle_q_reg) * SETTLE_UNIT_CYC);
        m.we = 1'b0;
        m.waddr = 6'h00;
        m.wdata = 12'h000;
        m.raddr_a = P1_BASE + {2'b00, idx_reg};
        case (state_reg)
            ST_IDLE: begin
                // A request seen outside idle is simply dropped
                if (scan_bit_reg) begin
                    state_next = ST_SETUP;
                    cnt_next = CNT_W'(SETUP_CYC - 1);
                    busy_next = 1'b1;
                    cell_q_next = cell_en_reg[NUM_CELLS-1:0];
                    opt_q_next = chan_cfg_reg[2:0];
                    settle_q_next = acq_cfg_reg[7:0];
                end
            end
            ST_SETUP: begin
                if (cnt_reg == '0) begin
                    nc = next_cell(cell_q_reg, 4'(NUM_CELLS));
                    idx_next = nc[3:0];
                    if (nc[4]) begin
                        state_next = ST_CELL1;
                        launch = 1'b1;
                        l_long = 1'b1;
                        l_chan = nc[3:0] + 4'h1;
                    end else begin
                        state_next = ST_WBACK;
                        wb_ph_next = 1'b0;
                    end
                end
            end
            ST_CELL1: begin
                if (cnt_reg == '0) begin
                    m.we = 1'b1;
                    m.waddr = P1_BASE + {2'b00, idx_reg};
                    m.wdata = adc_data;
                    nc = next_cell(cell_q_reg, idx_reg);
                    launch = 1'b1;
                    if (nc[4]) begin
                        idx_next = nc[3:0];
                    end else begin
                        nc = next_cell(cell_q_reg, 4'(NUM_CELLS));
                        idx_next = nc[3:0];
                        state_next = ST_CELL2;
                        l_long = 1'b1;
                        l_phase = 1'b1;
                    end
                    l_chan = nc[3:0] + 4'h1;
                end
            end
            ST_CELL2: begin
                if (cnt_reg == '0) begin
                    m.we = 1'b1;
                    m.waddr = P2_BASE + {2'b00, idx_reg};
                    // Chopped phases cancel the front-end offset when averaged
                    m.wdata = avg2(m.rdata_a, adc_data);
                    nc = next_cell(cell_q_reg, idx_reg);
                    if (nc[4]) begin
                        idx_next = nc[3:0];
                        launch = 1'b1;
                        l_phase = 1'b1;
                        l_chan = nc[3:0] + 4'h1;
                    end else begin
                        nc = next_cell(cell_q_reg, 4'(NUM_CELLS));
                        idx_next = nc[3:0];
                        state_next = ST_WBACK;
                        wb_ph_next = 1'b0;
                    end
                end
            end
            ST_WBACK: begin
                m.raddr_a = P2_BASE + {2'b00, idx_reg};
                if (!cell_q_reg[idx_reg]) begin
                    after_cells = 1'b1;
                end else if (!wb_ph_reg) begin
                    wb_ph_next = 1'b1;
                end else begin
                    m.we = 1'b1;
                    m.waddr = {2'b00, idx_reg};
                    m.wdata = m.rdata_a;
                    wb_ph_next = 1'b0;
                    nc = next_cell(cell_q_reg, idx_reg);
                    idx_next = nc[3:0];
                    after_cells = !nc[4];
                end
            end
            ST_DIAG1: begin
                if (cnt_reg == '0) begin
                    diag_p1_next = adc_data;
                    state_next = ST_DIAG2;
                    launch = 1'b1;
                    l_phase = 1'b1;
                    l_chan = CH_DIAG;
                end
            end
            ST_DIAG2: begin
                if (cnt_reg == '0) begin
                    m.we = 1'b1;
                    m.waddr = ADDR_DIAG;
                    m.wdata = avg2(diag_p1_reg, adc_data);
                    to_aux = 1'b1;
                end
            end
            ST_AUXSET: begin
                if (cnt_reg == '0) begin
                    state_next = ST_AUXCONV;
                    launch = 1'b1;
                    l_chan = CH_AUX1 + idx_reg;
                end
            end
            ST_AUXCONV: begin
                if (cnt_reg == '0) begin
                    m.we = 1'b1;
                    m.waddr = ADDR_AUX1 + {2'b00, idx_reg};
                    m.wdata = adc_data;
                    if (idx_reg == 4'h0 && opt_q_reg[AUX2_EN_BIT]) begin
                        state_next = ST_AUXSET;
                        idx_next = 4'h1;
                        cnt_next = settle_cyc;
                    end else begin
                        state_next = ST_IDLE;
                        busy_next = 1'b0;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
        if (after_cells) begin
            if (opt_q_reg[DIAG_EN_BIT]) begin
                state_next = ST_DIAG1;
                launch = 1'b1;
                l_chan = CH_DIAG;
            end else begin
                to_aux = 1'b1;
            end
        end
        if (to_aux) begin
            if (opt_q_reg[AUX1_EN_BIT] || opt_q_reg[AUX2_EN_BIT]) begin
                state_next = ST_AUXSET;
                idx_next = opt_q_reg[AUX1_EN_BIT] ? 4'h0 : 4'h1;
                cnt_next = settle_cyc;
            end else begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
            end
        end
        if (launch) begin
            cnt_next = l_long ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
            start_next = 1'b1;
            chan_next = l_chan;
            phase_next = l_phase;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            idx_reg <= 4'h0;
            cell_q_reg <= 12'h000;
            opt_q_reg <= 3'h0;
            settle_q_reg <= 8'h00;
            diag_p1_reg <= 12'h000;
            chan_reg <= 4'h0;
            phase_reg <= 1'b0;
            start_reg <= 1'b0;
            busy_reg <= 1'b0;
            wb_ph_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            cell_q_reg <= cell_q_next;
            opt_q_reg <= opt_q_next;
            settle_q_reg <= settle_q_next;
            diag_p1_reg <= diag_p1_next;
            chan_reg <= chan_next;
            phase_reg <= phase_next;
            start_reg <= start_next;
            busy_reg <= busy_next;
            wb_ph_reg <= wb_ph_next;
        end
    end

    // Read port: two-cycle latency for every address
    logic [7:0] rd_q_reg;
    logic [15:0] rd_data_reg, rd_data_next;
    // Results read zero until first written; the store itself has no reset
    logic [MEM_DEPTH-1:0] filled_reg, filled_next;
    logic rd_ok_reg, rd_ok_next;

    always_comb begin
        m.raddr_b = 6'h00;
        if (rd_addr >= OFS_CELL_DATA && rd_addr < OFS_AUX1) begin
            m.raddr_b = 6'(rd_addr - OFS_CELL_DATA);
        end else if (rd_addr == OFS_AUX1 || rd_addr == OFS_AUX2) begin
            m.raddr_b = ADDR_AUX1 + 6'(rd_addr - OFS_AUX1);
        end else if (rd_addr == OFS_DIAG) begin
            m.raddr_b = ADDR_DIAG;
        end
        filled_next = filled_reg;
        if (m.we) begin
            filled_next[m.waddr] = 1'b1;
        end
        rd_ok_next = filled_reg[m.raddr_b];
        case (rd_q_reg)
            OFS_CHAN_CFG: rd_data_next = chan_cfg_reg;
            OFS_CELL_EN: rd_data_next = cell_en_reg;
            OFS_ACQ_CFG: rd_data_next = acq_cfg_reg;
            OFS_SCAN_CTRL: rd_data_next = {14'h0000, busy_reg, scan_bit_reg};
            default: rd_data_next = (rd_q_reg >= OFS_CELL_DATA && rd_q_reg <= OFS_DIAG && rd_ok_reg) ?
                {4'h0, m.rdata_b} : 16'h0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_q_reg <= 8'h00;
            rd_data_reg <= 16'h0000;
            filled_reg <= '0;
            rd_ok_reg <= 1'b0;
        end else begin
            rd_q_reg <= rd_addr;
            rd_data_reg <= rd_data_next;
            filled_reg <= filled_next;
            rd_ok_reg <= rd_ok_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign adc_chan = chan_reg;
    assign adc_phase = phase_reg;
    assign adc_start = start_reg;
    assign busy = busy_reg;
    assign scan_fwd = fwd_reg;

    // Checks
    localparam int RELAY_D = RELAY_CYC + 1;
    logic [CNT_W-1:0] setup_len_reg;
    always_ff @(posedge mclk) begin
        setup_len_reg <= (state_reg == ST_SETUP) ? setup_len_reg + CNT_W'(1) : '0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_start_accept: assert property (scan_bit_reg && state_reg == ST_IDLE |=> state_reg == ST_SETUP && busy_reg)
        else $error("scan request in idle not accepted");
    a_busy_ignore: assert property (scan_bit_reg && state_reg != ST_IDLE
        |=> !(state_reg == ST_SETUP && cnt_reg == CNT_W'(SETUP_CYC - 1)))
        else $error("scan request restarted a running scan");
    a_scan_clear: assert property (scan_bit_reg && !wr_scan |=> !scan_bit_reg)
        else $error("scan bit did not clear itself");
    a_setup_len: assert property (state_reg == ST_SETUP && cnt_reg == '0 |-> setup_len_reg == CNT_W'(SETUP_CYC - 1))
        else $error("setup interval has wrong length");
    a_first_long: assert property ($rose(state_reg == ST_CELL1) || $rose(state_reg == ST_CELL2)
        |-> cnt_reg == CNT_W'(LONG_CYC - 1) && adc_start)
        else $error("first cell slot not long");
    a_cell_enabled: assert property (adc_start && adc_chan < CH_DIAG |-> cell_q_reg[adc_chan - 4'h1])
        else $error("disabled cell converted");
    a_order_desc: assert property (adc_start && $past(adc_start, 1) == 1'b0 && state_reg == ST_CELL1 && $past(state_reg) == ST_CELL1
        |-> idx_reg < $past(idx_reg))
        else $error("cell order not descending");
    a_diag_pair: assert property (state_reg == ST_DIAG1 && cnt_reg == '0 |=> state_reg == ST_DIAG2 && adc_start && adc_phase)
        else $error("diagnostic phase two not back to back");
    a_aux_enabled: assert property (state_reg == ST_AUXCONV |-> opt_q_reg[idx_reg[1:0]])
        else $error("disabled aux converted");
    a_keep_cells: assert property (m.we && m.waddr < ADDR_DIAG |-> cell_q_reg[m.waddr[3:0]] && state_reg == ST_WBACK)
        else $error("result of disabled cell written");
    a_relay_delay: assert property (wr_scan && w.bcast && !relay_act_reg |-> ##RELAY_D scan_fwd)
        else $error("scan relay delay wrong");

    c_full_scan: cover property (state_reg == ST_AUXCONV && idx_reg == 4'h1 && cnt_reg == '0);
    c_busy_drop: cover property (scan_bit_reg && busy_reg);
    c_diag_run: cover property (state_reg == ST_DIAG2 && cnt_reg == '0);
endmodule

// ==== test/host_model.sv ====
`timescale 1ns/1ns
module host_model (
    input wire logic link_clk,
    output logic link_wr,
    output logic link_bcast,
    output logic [7:0] link_addr,
    output logic [15:0] link_data
);
    initial begin
        link_wr = 1'b0;
        link_bcast = 1'b0;
        link_addr = 8'h00;
        link_data = 16'h0000;
    end
    // One decoded write, then a gap wide enough for the crossing into mclk
    task automatic wr(input logic bc, input logic [7:0] a, input logic [15:0] d);
        @(negedge link_clk);
        link_wr = 1'b1;
        link_bcast = bc;
        link_addr = a;
        link_data = d;
        @(negedge link_clk);
        link_wr = 1'b0;
        link_addr = ~a;
        link_data = ~d;
        repeat (8) @(negedge link_clk);
    endtask
endmodule

// ==== test/tb_scan_seq_top.sv ====
`timescale 1ns/1ns
module tb_scan_seq_top;
    import scan_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic link_clk = 1'b0;
    logic link_wr, link_bcast, adc_phase, adc_start, busy, scan_fwd;
    logic [7:0] link_addr;
    logic [7:0] rd_addr = 8'h00;
    logic [15:0] link_data, rd_data;
    logic [3:0] adc_chan;
    int error_cnt = 0, checks = 0, cyc = 0, t_busy = 0, t_fwd = 0, g0 = 0, g1 = 0;
    logic [4:0] qc[$];
    int qt[$];
    always #10 mclk = ~mclk;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    host_model host_u (.link_clk(link_clk), .link_wr(link_wr), .link_bcast(link_bcast),
        .link_addr(link_addr), .link_data(link_data));
    // Converter answer encodes channel and phase so order and averaging show up
    scan_seq_top dut_u (.mclk(mclk), .rst(rst), .link_clk(link_clk), .link_wr(link_wr),
        .link_bcast(link_bcast), .link_addr(link_addr), .link_data(link_data), .rd_addr(rd_addr),
        .rd_data(rd_data), .adc_data({adc_chan, 6'h00, adc_phase, 1'b0}), .adc_chan(adc_chan),
        .adc_phase(adc_phase), .adc_start(adc_start), .busy(busy), .scan_fwd(scan_fwd));
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (adc_start === 1'b1) begin
            qc.push_back({adc_phase, adc_chan});
            qt.push_back(cyc);
        end
        if (scan_fwd === 1'b1) t_fwd <= cyc;
        if (busy === 1'b1 && t_busy < 0) t_busy <= cyc;
    end
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        @(negedge mclk);
        rd_addr = a;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(rd_data, e);
    endtask
    task automatic wt(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl) begin
            @(negedge mclk);
            n++;
            if (n > lim) begin
                error_cnt++;
                summarize();
            end
        end
    endtask
    // A second, addressed request lands during setup and must be dropped
    task automatic scan(input logic bc, input logic [4:0] e[$]);
        qc = {};
        qt = {};
        t_fwd = -1;
        t_busy = -1;
        host_u.wr(bc, OFS_SCAN_CTRL, 16'h0001);
        wt(1'b1, 40);
        repeat (300) @(negedge mclk);
        host_u.wr(1'b0, OFS_SCAN_CTRL, 16'h0001);
        wt(1'b0, 20000);
        chk(16'(qc.size()), 16'(e.size()));
        foreach (e[i]) chk(16'(qc[i]), 16'(e[i]));
        chk(16'(qt[0] - t_busy), 16'(SETUP_CYC));
        // Busy rises one cycle after the scan bit; the relay counts from the scan bit
        chk(16'(bc ? t_fwd - t_busy : t_fwd), bc ? 16'(RELAY_CYC - 1) : 16'hffff);
    endtask
    task automatic t_reset();
        rchk(OFS_CHAN_CFG, REG_RESET);
        rchk(OFS_CELL_EN, REG_RESET);
        rchk(OFS_ACQ_CFG, REG_RESET);
        chk(16'(busy), 16'h0000);
    endtask
    task automatic t_regs();
        host_u.wr(1'b0, OFS_CELL_EN, 16'h0805);
        host_u.wr(1'b0, OFS_CHAN_CFG, 16'h0005);
        host_u.wr(1'b0, OFS_ACQ_CFG, 16'hff00);
        host_u.wr(1'b0, 8'h05, 16'hffff);
        rchk(OFS_CELL_EN, 16'h0805);
        rchk(OFS_CHAN_CFG, 16'h0005);
        rchk(OFS_ACQ_CFG, 16'hff00);
        rchk(8'h05, 16'h0000);
    endtask
    task automatic t_scan_a();
        scan(1'b1, '{5'h0c, 5'h03, 5'h01, 5'h1c, 5'h13, 5'h11, 5'h0d, 5'h1d, 5'h0e});
        chk(16'(qt[1] - qt[0]), 16'(LONG_CYC));
        chk(16'(qt[2] - qt[1]), 16'(SHORT_CYC));
        chk(16'(qt[4] - qt[3]), 16'(LONG_CYC));
        rchk(OFS_CELL_DATA + 8'h0b, 16'h0c01);
        rchk(OFS_CELL_DATA + 8'h02, 16'h0301);
        rchk(OFS_CELL_DATA, 16'h0101);
        rchk(OFS_CELL_DATA + 8'h01, 16'h0000);
        rchk(OFS_AUX1, 16'h0e00);
        rchk(OFS_AUX2, 16'h0000);
        rchk(OFS_DIAG, 16'h0d01);
        rchk(OFS_SCAN_CTRL, 16'h0000);
    endtask
    task automatic t_scan_b();
        host_u.wr(1'b0, OFS_CELL_EN, 16'h0002);
        host_u.wr(1'b0, OFS_CHAN_CFG, 16'h0003);
        scan(1'b0, '{5'h02, 5'h12, 5'h0e, 5'h0f});
        g0 = qt[3] - qt[2];
        g1 = qt[2] - qt[1];
        rchk(OFS_CELL_DATA + 8'h01, 16'h0201);
        rchk(OFS_CELL_DATA + 8'h0b, 16'h0c01);
        rchk(OFS_AUX2, 16'h0f00);
        host_u.wr(1'b0, OFS_ACQ_CFG, 16'h0002);
        scan(1'b0, '{5'h02, 5'h12, 5'h0e, 5'h0f});
        chk(16'(qt[3] - qt[2] - g0), 16'(2 * SETTLE_UNIT_CYC));
        chk(16'(qt[2] - qt[1] - g1), 16'(2 * SETTLE_UNIT_CYC));
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        repeat (12) @(negedge mclk);
        t_reset();
        t_regs();
        t_scan_a();
        t_scan_b();
        summarize();
    end
endmodule
